// >>> sim/fmcir_tb.sv
// Self-checking bench for the fan monitor configuration and interrupt register bank.
// Assumes the register bank with its default of four speed inputs and one clock.
`timescale 1ns/10ps
module testbench;
    import fmcir_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    fmcir_byte_type reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, temp_ok = 1'b0;
    logic [3:0] ev = 4'h0, sts;
    logic [63:0] lim = 64'h0;
    logic [23:0] duty = 24'h404040;
    logic [2:0] dis = 3'h0;
    logic t3, p2, sup, srp, alert_n, irq;
    logic [7:0] sel;
    fmcir_byte_type exp_q[$];
    int num_errors = 0, tests_run = 0;
    integer seed = 32'hacf94fbd;
    always #20 clk = ~clk;
    fmcir_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_reading_valid(temp_ok),
        .speed_limit_event(ev), .speed_min_limit(lim), .drive_duty(duty),
        .drive_fan_disabled(dis), .third_sense_pin_alert_select(t3),
        .second_drive_pin_alert_select(p2), .spinup_shortening_enable(sup),
        .soft_reset_pulse(srp), .speed_drive_sel(sel), .speed_status(sts),
        .alert_n(alert_n), .irq(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // The expected value is queued; the watcher below compares it when the data appear.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) if (rd_d) chk(reg_rdata, exp_q.pop_front());
    task automatic pulse_events;
        @(posedge clk);
        ev <= 4'hf;
        @(posedge clk);
        ev <= 4'h0;
        #1;
    endtask
    task report_and_stop;
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(40 * 3000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h7f, 8'h10);
        rd(8'h80, 8'h1e);
        rd(8'h81, 8'ha4);
        rd(8'hf0, 8'h00);
        rd(8'h33, 8'h00);
        temp_ok <= 1'b1;
        wr(8'h7f, 8'h03);
        chk({5'h0, t3, p2, sup}, 8'h06);
        rd(8'h7f, 8'h0b);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(8'h81, v);
            chk(sel, v);
            rd(8'h81, v);
        end
        wr(8'h81, 8'ha4);
        pulse_events();
        rd(8'hf1, 8'h0f);
        chk({7'h0, irq}, 8'h00);
        wr(8'hf2, 8'h0f);
        chk({6'h0, irq, alert_n}, 8'h03);
        wr(8'h80, 8'h1f);
        wr(8'hf0, 8'h01);
        chk({7'h0, alert_n}, 8'h00);
        wr(8'h80, 8'h1e);
        chk({7'h0, alert_n}, 8'h01);
        wr(8'hf1, 8'h0f);
        chk({3'h0, irq, sts}, 8'h00);
        duty <= 24'h404000;
        dis <= 3'b010;
        lim <= {16'h0, 16'hffff, 32'h0};
        wr(8'h80, 8'h0f);
        pulse_events();
        rd(8'hf1, 8'h00);
        wr(8'hf2, 8'h05);
        wr(8'h7f, 8'h80);
        chk({7'h0, srp}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h0, srp}, 8'h00);
        rd(8'h7f, 8'h18);
        rd(8'h80, 8'h1e);
        rd(8'hf2, 8'h00);
        rd(8'hf0, 8'h00);
        wr(8'hf0, 8'h02);
        wr(8'h7f, 8'h01);
        wr(8'h80, 8'h00);
        wr(8'h81, 8'h00);
        rd(8'h7f, 8'h18);
        rd(8'h80, 8'h1e);
        rd(8'h81, 8'ha4);
        chk({7'h0, t3}, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        wr(8'h81, 8'h1b);
        rd(8'h81, 8'h1b);
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule // testbench

// >>> src/fmcir_params.svh
// Constants of the fan monitor configuration and interrupt register bank.
// Assumes an 8-bit register port with byte offsets and a single core clock.
// What this block does
// [R1] Once lock is set, config, speed enable and association registers ignore writes.
// [R2] Config bit 0 selects third speed pin: speed input or alert output.
// [R3] Config bit 1 selects second drive pin: drive output or alert output.
// [R4] Config bit 3 is read-only, shows temperature readings valid, resets 0.
// [R5] Config bit 4 resets 1 and enables spin-up shortening from speed feedback.
// [R6] Writing 1 to config bit 7 starts a soft reset; bit self-clears.
// [R7] Soft reset restores all registers to defaults except measurement readings.
// [R8] Software keeps config bits 5 and 6 at zero.
// [R9] Speed enable bits 1 to 4 gate status updates per input, reset 1.
// [R10] Speed group enable and global enable both needed for alert pin.
// [R11] Two-bit field selects drive output one, two or three; 11 reserved.
// [R12] Fields at 1:0,3:2,5:4,7:6; association register resets to a4.
// [R13] No status set while associated drive duty equals zero.
// [R14] No status set while associated fan is disabled.
// [R15] No status set when the input's minimum limit is ffff.
// [R16] Software runs unassociated drive outputs in the first drive mode.
// [R17] Software associates every input; unused ones use mode one, irq disabled.
// [R18] Global interrupt enable must be set before alert pin function acts; resets 0.
// [R19] Soft reset pulse is one cycle; reset bit reads back zero.
`ifndef FMCIR_PARAMS_SVH
`define FMCIR_PARAMS_SVH
`define FMCIR_ADDR_CFG 8'h7f
`define FMCIR_ADDR_SPDEN 8'h80
`define FMCIR_ADDR_ASSOC 8'h81
`define FMCIR_ADDR_CTRL 8'hf0
`define FMCIR_ADDR_STAT 8'hf1
`define FMCIR_ADDR_MASK 8'hf2
`define FMCIR_CFG_RST 8'h10
`define FMCIR_SPDEN_RST 8'h1e
`define FMCIR_ASSOC_RST 8'ha4
`define FMCIR_CTRL_RST 8'h00
`define FMCIR_MASK_RST 8'h00
`define FMCIR_CFG_WMASK 8'h73
`define FMCIR_CFG_RMASK 8'h7b
`define FMCIR_SPDEN_WMASK 8'h1f
`define FMCIR_CTRL_WMASK 8'h03
`define FMCIR_B_T3SEL 0
`define FMCIR_B_P2SEL 1
`define FMCIR_B_TEMP_READING_VALID 3
`define FMCIR_B_SPINUP_SHORTENING_ENABLE 4
`define FMCIR_B_INIT 7
`define FMCIR_B_GROUP 0
`define FMCIR_B_GIEN 0
`define FMCIR_B_LOCK 1
`define FMCIR_LIMIT_OFF 16'hffff
`define FMCIR_DUTY_OFF 8'h00
`define FMCIR_SEL_RSVD 2'h3
`endif

// >>> src/fmcir_pkg.sv
// Types of the fan monitor configuration and interrupt register bank.
// Assumes inclusion of nothing; used by the register bank module.
package fmcir_pkg;
    typedef logic [1:0] fmcir_sel_type;
    typedef logic [7:0] fmcir_byte_type;
endpackage

// >>> src/fmcir_regs.sv
// Register bank for pin function, speed interrupt enables and speed-to-drive association.
// Assumes one clock domain; fan and measurement inputs come from logic on the same clock.
`timescale 1ns/10ps
`include "fmcir_params.svh"
module fmcir_regs #(
    parameter int NUM_SPEED = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire fmcir_pkg::fmcir_byte_type reg_addr,
    input wire fmcir_pkg::fmcir_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output fmcir_pkg::fmcir_byte_type reg_rdata,
    input wire logic temp_reading_valid,
    input wire logic [NUM_SPEED-1:0] speed_limit_event,
    input wire logic [NUM_SPEED*16-1:0] speed_min_limit,
    input wire logic [23:0] drive_duty,
    input wire logic [2:0] drive_fan_disabled,
    output logic third_sense_pin_alert_select,
    output logic second_drive_pin_alert_select,
    output logic spinup_shortening_enable,
    output logic soft_reset_pulse,
    output logic [NUM_SPEED*2-1:0] speed_drive_sel,
    output logic [NUM_SPEED-1:0] speed_status,
    output logic alert_n,
    output logic irq
);
    import fmcir_pkg::*;

    fmcir_byte_type cfg_r, cfg_nxt;
    fmcir_byte_type spden_r, spden_nxt;
    fmcir_byte_type assoc_r, assoc_nxt;
    fmcir_byte_type ctrl_r, ctrl_nxt;
    fmcir_byte_type mask_r, mask_nxt;
    logic [NUM_SPEED-1:0] stat_r, stat_nxt;
    logic [NUM_SPEED-1:0] qual;
    logic srst_r, srst_nxt;
    logic lock;
    fmcir_byte_type rdata_nxt;
    fmcir_byte_type stat_byte;
    logic alert_cond;

    function automatic logic [7:0] duty_of(input logic [23:0] duty, input fmcir_sel_type sel);
        duty_of = duty[8*sel +: 8];
    endfunction

    function automatic logic fan_off(input logic [2:0] dis, input fmcir_sel_type sel);
        fan_off = dis[sel];
    endfunction

    assign lock = ctrl_r[`FMCIR_B_LOCK];
    assign stat_byte = 8'(stat_r);

    // A speed event only counts when its drive runs and its limit is armed.
    genvar g;
    generate
        for (g = 0; g < NUM_SPEED; g++) begin : g_qual
            fmcir_sel_type sel;
            assign sel = assoc_r[2*g +: 2]; // [R11] [R12]
            assign qual[g] = speed_limit_event[g]
                && spden_r[g+1] // [R9]
                && (sel != `FMCIR_SEL_RSVD)
                && (duty_of(drive_duty, sel) != `FMCIR_DUTY_OFF) // [R13]
                && !fan_off(drive_fan_disabled, sel) // [R14]
                && (speed_min_limit[16*g +: 16] != `FMCIR_LIMIT_OFF); // [R15]

            // Each blocking condition alone must keep a clear status bit clear.
            AST_EN_BLOCK: assert property (@(posedge clk) // [R9]
                disable iff (sys_rst)
                !spden_r[g+1] && !stat_r[g] && !srst_r |=> !stat_r[g])
                else $error("Status set for a disabled speed input.");

            AST_RSVD_BLOCK: assert property (@(posedge clk) // [R11]
                disable iff (sys_rst)
                sel == `FMCIR_SEL_RSVD && !stat_r[g] && !srst_r |=> !stat_r[g])
                else $error("Status set through a reserved association code.");

            AST_DUTY_BLOCK: assert property (@(posedge clk) // [R13]
                disable iff (sys_rst)
                sel != `FMCIR_SEL_RSVD && duty_of(drive_duty, sel) == `FMCIR_DUTY_OFF
                && !stat_r[g] && !srst_r |=> !stat_r[g])
                else $error("Status set while the associated duty is zero.");

            AST_FAN_OFF_BLOCK: assert property (@(posedge clk) // [R14]
                disable iff (sys_rst)
                sel != `FMCIR_SEL_RSVD && fan_off(drive_fan_disabled, sel)
                && !stat_r[g] && !srst_r |=> !stat_r[g])
                else $error("Status set while the associated fan is disabled.");

            AST_LIMIT_BLOCK: assert property (@(posedge clk) // [R15]
                disable iff (sys_rst)
                speed_min_limit[16*g +: 16] == `FMCIR_LIMIT_OFF
                && !stat_r[g] && !srst_r |=> !stat_r[g])
                else $error("Status set with the minimum limit switched off.");

            AST_STAT_SET: assert property (@(posedge clk) // [R9]
                disable iff (sys_rst)
                speed_limit_event[g] && spden_r[g+1] && sel != `FMCIR_SEL_RSVD
                && duty_of(drive_duty, sel) != `FMCIR_DUTY_OFF
                && !fan_off(drive_fan_disabled, sel)
                && speed_min_limit[16*g +: 16] != `FMCIR_LIMIT_OFF && !srst_r |=> stat_r[g])
                else $error("Qualified speed event did not set status.");

            AST_STAT_STICKY: assert property (@(posedge clk) // [R9]
                disable iff (sys_rst)
                stat_r[g] && !srst_r && !(reg_wr && reg_addr == `FMCIR_ADDR_STAT && reg_wdata[g])
                |=> stat_r[g])
                else $error("Status bit dropped without a clear.");
        end
    endgenerate

    always_comb begin
        cfg_nxt = cfg_r;
        spden_nxt = spden_r;
        assoc_nxt = assoc_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        srst_nxt = 1'b0;
        if (reg_wr && !lock) begin // [R1]
            unique case (reg_addr)
                `FMCIR_ADDR_CFG: begin
                    cfg_nxt = reg_wdata & `FMCIR_CFG_WMASK;
                    srst_nxt = reg_wdata[`FMCIR_B_INIT]; // [R6]
                end
                `FMCIR_ADDR_SPDEN: spden_nxt = reg_wdata & `FMCIR_SPDEN_WMASK;
                `FMCIR_ADDR_ASSOC: assoc_nxt = reg_wdata;
                default: begin
                end
            endcase
        end
        if (reg_wr) begin
            unique case (reg_addr)
                `FMCIR_ADDR_CTRL: begin
                    // Lock can be set by software but only a reset clears it.
                    ctrl_nxt = reg_wdata & `FMCIR_CTRL_WMASK;
                    ctrl_nxt[`FMCIR_B_LOCK] = reg_wdata[`FMCIR_B_LOCK] | lock; // [R1]
                end
                `FMCIR_ADDR_STAT: stat_nxt = stat_r & ~reg_wdata[NUM_SPEED-1:0];
                `FMCIR_ADDR_MASK: mask_nxt = reg_wdata;
                default: begin
                end
            endcase
        end
        stat_nxt = stat_nxt | qual;
        if (srst_r) begin // [R7] [R19]
            cfg_nxt = `FMCIR_CFG_RST;
            spden_nxt = `FMCIR_SPDEN_RST;
            assoc_nxt = `FMCIR_ASSOC_RST;
            ctrl_nxt = `FMCIR_CTRL_RST;
            mask_nxt = `FMCIR_MASK_RST;
            stat_nxt = '0;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `FMCIR_ADDR_CFG: begin
                    rdata_nxt = cfg_r;
                    rdata_nxt[`FMCIR_B_TEMP_READING_VALID] = temp_reading_valid; // [R4]
                end
                `FMCIR_ADDR_SPDEN: rdata_nxt = spden_r;
                `FMCIR_ADDR_ASSOC: rdata_nxt = assoc_r;
                `FMCIR_ADDR_CTRL: rdata_nxt = ctrl_r;
                `FMCIR_ADDR_STAT: rdata_nxt = stat_byte;
                `FMCIR_ADDR_MASK: rdata_nxt = mask_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_r <= `FMCIR_CFG_RST;
            spden_r <= `FMCIR_SPDEN_RST;
            assoc_r <= `FMCIR_ASSOC_RST;
            ctrl_r <= `FMCIR_CTRL_RST;
            mask_r <= `FMCIR_MASK_RST;
            stat_r <= '0;
            srst_r <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            cfg_r <= cfg_nxt;
            spden_r <= spden_nxt;
            assoc_r <= assoc_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            srst_r <= srst_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // Alert pin: pending speed status, group enable and global enable together.
    assign alert_cond = |stat_r && spden_r[`FMCIR_B_GROUP] && ctrl_r[`FMCIR_B_GIEN]; // [R10] [R18]
    assign alert_n = !alert_cond;
    assign irq = |(stat_byte & mask_r);
    assign third_sense_pin_alert_select = cfg_r[`FMCIR_B_T3SEL]; // [R2]
    assign second_drive_pin_alert_select = cfg_r[`FMCIR_B_P2SEL]; // [R3]
    assign spinup_shortening_enable = cfg_r[`FMCIR_B_SPINUP_SHORTENING_ENABLE]; // [R5]
    assign soft_reset_pulse = srst_r; // [R19]
    assign speed_drive_sel = assoc_r[NUM_SPEED*2-1:0];
    assign speed_status = stat_r;

    AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        lock && !srst_r |=> $stable(assoc_r) && $stable(spden_r))
        else $error("Locked register changed.");
    AST_SRST_ONE: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
        srst_r |=> !srst_r)
        else $error("Soft reset pulse longer than one cycle.");
    AST_SRST_START: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        reg_wr && !lock && reg_addr == `FMCIR_ADDR_CFG && reg_wdata[`FMCIR_B_INIT] |=> srst_r)
        else $error("Soft reset not started.");
    AST_SRST_DEFAULTS: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        srst_r |=> assoc_r == `FMCIR_ASSOC_RST && cfg_r == `FMCIR_CFG_RST)
        else $error("Soft reset did not restore defaults.");
    AST_INIT_READS_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
        reg_rd && reg_addr == `FMCIR_ADDR_CFG |=> !reg_rdata[`FMCIR_B_INIT])
        else $error("Reset bit read back as one.");
    AST_TEMP_READING_VALID: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        reg_rd && reg_addr == `FMCIR_ADDR_CFG
        |=> reg_rdata[`FMCIR_B_TEMP_READING_VALID] == $past(temp_reading_valid))
        else $error("Temperature valid bit wrong.");
    AST_ALERT: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        !ctrl_r[`FMCIR_B_GIEN] || !spden_r[`FMCIR_B_GROUP] |-> alert_n)
        else $error("Alert driven without enables.");
    AST_NO_STATUS: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
        speed_min_limit[47:32] == `FMCIR_LIMIT_OFF && !stat_r[2] && !srst_r |=> !stat_r[2])
        else $error("Status set with disabled limit.");
    AST_PIN_SEL: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
        third_sense_pin_alert_select == cfg_r[0] && second_drive_pin_alert_select == cfg_r[1])
        else $error("Pin select mismatch.");

    AST_CFG_LOCKED: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        lock && !srst_r |=> $stable(cfg_r))
        else $error("Locked configuration changed.");

    AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        lock && !srst_r |=> lock)
        else $error("Lock cleared without a reset.");

    AST_SRST_BLOCKED: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
        lock |=> !srst_r)
        else $error("Soft reset started while locked.");

    AST_PIN_DEFAULTS: assert property (@(posedge clk) disable iff (sys_rst) // [R2] [R3]
        srst_r |=> !third_sense_pin_alert_select && !second_drive_pin_alert_select)
        else $error("Pin selects not back at default.");

    AST_SPINUP_SHORTENING_ENABLE_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        srst_r |=> spinup_shortening_enable)
        else $error("Spin-up shortening not enabled after soft reset.");

    AST_CFG_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // [R2] [R3]
        reg_wr && !lock && !srst_r && reg_addr == `FMCIR_ADDR_CFG
        |=> third_sense_pin_alert_select == $past(reg_wdata[`FMCIR_B_T3SEL])
        && second_drive_pin_alert_select == $past(reg_wdata[`FMCIR_B_P2SEL]))
        else $error("Pin select did not follow the write.");

    AST_SPINUP_SHORTENING_ENABLE_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
        reg_wr && !lock && !srst_r && reg_addr == `FMCIR_ADDR_CFG
        |=> spinup_shortening_enable == $past(reg_wdata[`FMCIR_B_SPINUP_SHORTENING_ENABLE]))
        else $error("Spin-up shortening did not follow the write.");

    AST_SPDEN_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // [R7] [R9]
        srst_r |=> spden_r == `FMCIR_SPDEN_RST)
        else $error("Speed enables not back at default.");

    AST_SRST_CLEARS: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        srst_r |=> stat_r == '0 && !lock)
        else $error("Soft reset left status or lock set.");

    AST_MASK_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
        srst_r |=> mask_r == `FMCIR_MASK_RST && !irq)
        else $error("Mask not back at default.");

    AST_GIEN_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
        srst_r |=> !ctrl_r[`FMCIR_B_GIEN] && alert_n)
        else $error("Global enable not cleared by soft reset.");

    AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
        reg_wr && !srst_r && reg_addr == `FMCIR_ADDR_CTRL
        |=> ctrl_r[`FMCIR_B_GIEN] == $past(reg_wdata[`FMCIR_B_GIEN]))
        else $error("Global enable did not follow the write.");

    AST_ALERT_SET: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        |stat_r && spden_r[`FMCIR_B_GROUP] && ctrl_r[`FMCIR_B_GIEN] |-> !alert_n)
        else $error("Alert not driven with both enables set.");

    AST_SPDEN_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        reg_wr && !lock && !srst_r && reg_addr == `FMCIR_ADDR_SPDEN
        |=> spden_r == ($past(reg_wdata) & `FMCIR_SPDEN_WMASK))
        else $error("Speed enables did not follow the write.");

    AST_SPDEN_SPARE: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        (spden_r & ~`FMCIR_SPDEN_WMASK) == 8'h00)
        else $error("Spare speed enable bits set.");

    AST_ASSOC_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        reg_wr && !lock && !srst_r && reg_addr == `FMCIR_ADDR_ASSOC
        |=> assoc_r == $past(reg_wdata))
        else $error("Association did not follow the write.");

    AST_CFG_SPARE: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
        reg_rd && reg_addr == `FMCIR_ADDR_CFG |=> (reg_rdata & ~`FMCIR_CFG_RMASK) == 8'h00)
        else $error("Reserved configuration bits read as one.");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data shown without a read.");

    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
        (stat_byte & mask_r) != 8'h00 |-> irq)
        else $error("Interrupt low with an unmasked status bit.");

    AST_STAT_RDATA: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        reg_rd && reg_addr == `FMCIR_ADDR_STAT |=> reg_rdata == $past(stat_byte))
        else $error("Status read back wrong.");

    AST_SPDEN_RDATA: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
        reg_rd && reg_addr == `FMCIR_ADDR_SPDEN |=> reg_rdata == $past(spden_r))
        else $error("Speed enables read back wrong.");

    AST_ASSOC_RDATA: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        reg_rd && reg_addr == `FMCIR_ADDR_ASSOC |=> reg_rdata == $past(assoc_r))
        else $error("Association read back wrong.");

    COV_SRST: cover property (@(posedge clk) srst_r);
    COV_ALERT: cover property (@(posedge clk) !alert_n);
    COV_LOCK_WR: cover property (@(posedge clk) lock && reg_wr && reg_addr == `FMCIR_ADDR_ASSOC);
    COV_STATUS: cover property (@(posedge clk) stat_r != '0);
    COV_IRQ: cover property (@(posedge clk) irq);
endmodule // fmcir_regs
